/* rtl/pacw_access_timer.sv */
// Purpose: holds each cpu register access for its region's wait time
//          before signalling completion to the cpu.
// Assumes: peripheral clocks are integer divisions of the core clock,
//          given as ratios; ratio 1 (or 0) means equal clocks.
// Notes:   one access at a time; next request taken after the ready
//          pulse.
`timescale 1ns/1ns

module pacw_access_timer (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire logic                            cpuReq,
  input  wire logic                            cpuWrite,
  input  wire logic                            cpuHalf,
  input  wire logic [pacw_pkg::ADDR_W-1:0]     cpuAddr,
  input  wire logic [pacw_pkg::DATA_W-1:0]     cpuWdata,
  output logic      [pacw_pkg::DATA_W-1:0]     cpuRdata,
  output logic                                 cpuReady,
  output logic                                 cpuBusy,
  output logic                                 cpuUnmapped,
  output logic                                 perSel,
  output logic                                 perWrite,
  output logic      [pacw_pkg::ADDR_W-1:0]     perAddr,
  output logic      [pacw_pkg::DATA_W-1:0]     perWdata,
  input  wire logic [pacw_pkg::DATA_W-1:0]     perRdata,
  input  wire logic                            otherMasterBusy,
  input  wire logic                            clkSwitchBusy,
  input  wire logic [pacw_pkg::RATIO_W-1:0]    pclkaRatio,
  input  wire logic [pacw_pkg::RATIO_W-1:0]    pclkbRatio
);

  // ==========================================================
  // declarations
  pacw_dec_if dec ();                                  // decode carrier

  pacw_pkg::pacw_state_t           state_q;            // access phase
  logic [pacw_pkg::CNT_W-1:0]      cnt_q;              // units elapsed
  logic [pacw_pkg::CNT_W-1:0]      target_q;           // units required
  pacw_pkg::pacw_dom_t             dom_q;              // unit clock
  logic [pacw_pkg::RATIO_W-1:0]    phA_q;              // clock A phase
  logic [pacw_pkg::RATIO_W-1:0]    phB_q;              // clock B phase
  logic                            unmapped_q;         // miss latched
  logic [pacw_pkg::DATA_W-1:0]     cpuRdata_q;         // read result
  logic                            cpuReady_q;         // done pulse
  logic                            cpuBusy_q;          // access open
  logic                            cpuUnmapped_q;      // miss pulse
  logic                            perSel_q;           // peripheral strobe
  logic                            perWrite_q;         // direction
  logic [pacw_pkg::ADDR_W-1:0]     perAddr_q;          // held address
  logic [pacw_pkg::DATA_W-1:0]     perWdata_q;         // held write data

  logic                            accept;             // request taken
  logic                            tickA;              // clock A edge
  logic                            tickB;              // clock B edge
  logic                            unitTick;           // unit elapsed
  logic                            lastUnit;           // final unit now
  logic [pacw_pkg::CNT_W-1:0]      target_d;           // units for req

  // ==========================================================
  // functions

  // a ratio of zero would stall forever; treat it as equal clocks
  function automatic logic [pacw_pkg::RATIO_W-1:0] effRatio(
    input logic [pacw_pkg::RATIO_W-1:0] r
  );
    effRatio = (r == pacw_pkg::PHASE_ZERO) ? pacw_pkg::RATIO_ONE : r;
  endfunction

  // last core cycle of a peripheral period
  function automatic logic isLastPhase(
    input logic [pacw_pkg::RATIO_W-1:0] ph,
    input logic [pacw_pkg::RATIO_W-1:0] r
  );
    isLastPhase = (ph >= effRatio(r) - pacw_pkg::RATIO_ONE);
  endfunction

  // ==========================================================
  // region decode
  assign dec.addr = cpuAddr;

  pacw_region_dec u_dec (
    .dec (dec)
  );

  // ==========================================================
  // combinational control

  // no new access while another master holds the bus [RL13]
  assign accept = (state_q == pacw_pkg::ST_IDLE) && cpuReq &&
                  !otherMasterBusy; // [RL13]

  // units for the incoming request; misses get a fixed short answer
  always_comb begin
    if (!dec.hit) begin
      target_d = pacw_pkg::UNMAPPED_CYC; // [RL12]
    end else if (cpuWrite) begin
      target_d = dec.wrCyc; // [RL14]
    end else begin
      target_d = dec.rdCyc; // [RL14]
    end
    // wide serial data register takes two more units when cpuHalf is set [RL4]
    if (dec.hit && dec.wide && cpuHalf) begin
      target_d = target_d + pacw_pkg::SCI_WIDE_EXTRA; // [RL4]
    end
  end

  // peripheral edges seen from the core side
  assign tickA = isLastPhase(phA_q, pclkaRatio);
  assign tickB = isLastPhase(phB_q, pclkbRatio);

  // the first unit on a slower peripheral clock is partial: waiting for
  // its edge is the synchronisation cycle; at equal clocks every core
  // cycle is an edge, so the overhead stays fixed [RL11]
  always_comb begin
    case (dom_q)
      pacw_pkg::DOM_PA: begin
        unitTick = tickA; // [RL7] [RL11]
      end
      pacw_pkg::DOM_PB: begin
        unitTick = tickB; // [RL3] [RL5] [RL6] [RL8] [RL11]
      end
      default: begin
        unitTick = 1'b1; // [RL1] [RL2]
      end
    endcase
  end

  // clock source or divider changes freeze the count, so figures
  // stay minimums and switching time is added on top [RL10]
  assign lastUnit = (state_q == pacw_pkg::ST_WAIT) && unitTick &&
                    !clkSwitchBusy &&
                    (cnt_q + pacw_pkg::CNT_ONE == target_q); // [RL10]

  // ==========================================================
  // peripheral clock phase dividers, free running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phA_q <= pacw_pkg::PHASE_ZERO;
      phB_q <= pacw_pkg::PHASE_ZERO;
    end else begin
      // wrap at ratio; a ratio change applies to the period in progress
      phA_q <= tickA ? pacw_pkg::PHASE_ZERO
                     : phA_q + pacw_pkg::RATIO_ONE;
      phB_q <= tickB ? pacw_pkg::PHASE_ZERO
                     : phB_q + pacw_pkg::RATIO_ONE;
    end
  end

  // ==========================================================
  // access state machine
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= pacw_pkg::ST_IDLE;
    end else begin
      case (state_q)
        pacw_pkg::ST_IDLE: begin
          if (accept) begin
            state_q <= pacw_pkg::ST_WAIT;
          end
        end
        pacw_pkg::ST_WAIT: begin
          if (lastUnit) begin
            state_q <= pacw_pkg::ST_DONE; // [RL14]
          end
        end
        pacw_pkg::ST_DONE: begin
          state_q <= pacw_pkg::ST_IDLE;
        end
        default: begin
          state_q <= pacw_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // wait counter and per-access settings
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= '0;
      target_q   <= '0;
      dom_q      <= pacw_pkg::DOM_CORE;
      unmapped_q <= 1'b0;
    end else if (accept) begin
      cnt_q      <= '0;
      target_q   <= target_d;
      // misses are answered on the core clock
      dom_q      <= dec.hit ? dec.dom : pacw_pkg::DOM_CORE;
      unmapped_q <= !dec.hit; // [RL12]
    end else if ((state_q == pacw_pkg::ST_WAIT) && unitTick &&
                 !clkSwitchBusy) begin
      cnt_q <= cnt_q + pacw_pkg::CNT_ONE; // [RL14]
    end
  end

  // ==========================================================
  // peripheral side strobe and held request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      perSel_q   <= 1'b0;
      perWrite_q <= 1'b0;
      perAddr_q  <= '0;
      perWdata_q <= '0;
    end else if (accept) begin
      // unallocated addresses never reach a peripheral
      perSel_q   <= dec.hit;
      perWrite_q <= cpuWrite;
      perAddr_q  <= cpuAddr;
      perWdata_q <= cpuWdata;
    end else if (lastUnit) begin
      perSel_q <= 1'b0;
    end
  end

  // ==========================================================
  // cpu side completion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuReady_q    <= 1'b0;
      cpuUnmapped_q <= 1'b0;
      cpuRdata_q    <= '0;
    end else begin
      cpuReady_q    <= lastUnit; // [RL14]
      cpuUnmapped_q <= lastUnit && unmapped_q;
      if (lastUnit && !perWrite_q) begin
        // misses read as zero rather than stale data
        cpuRdata_q <= unmapped_q ? '0 : perRdata;
      end
    end
  end

  // busy from acceptance until the ready pulse has been shown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuBusy_q <= 1'b0;
    end else if (accept) begin
      cpuBusy_q <= 1'b1;
    end else if (state_q == pacw_pkg::ST_DONE) begin
      cpuBusy_q <= 1'b0;
    end
  end

  // ==========================================================
  // outputs straight from flip-flops
  assign cpuRdata    = cpuRdata_q;
  assign cpuReady    = cpuReady_q;
  assign cpuBusy     = cpuBusy_q;
  assign cpuUnmapped = cpuUnmapped_q;
  assign perSel      = perSel_q;
  assign perWrite    = perWrite_q;
  assign perAddr     = perAddr_q;
  assign perWdata    = perWdata_q;

endmodule // pacw_access_timer

/* rtl/pacw_dec_if.sv */
// Purpose: carries one address and its decoded region between modules.
// Assumes: purely combinational path.
// Notes:   rd/wr are zero when no region matches.
`timescale 1ns/1ns

// ==========================================================
// decode carrier
interface pacw_dec_if;
  logic [pacw_pkg::ADDR_W-1:0] addr;  // address under decode
  logic                        hit;   // some region matched
  logic [pacw_pkg::CNT_W-1:0]  rdCyc; // read units
  logic [pacw_pkg::CNT_W-1:0]  wrCyc; // write units
  pacw_pkg::pacw_dom_t         dom;   // unit clock
  logic                        wide;  // wide serial data region

  modport decoder (input addr, output hit, rdCyc, wrCyc, dom, wide);
  modport user    (output addr, input hit, rdCyc, wrCyc, dom, wide);
endinterface

/* rtl/pacw_pkg.sv */
// Purpose: shared constants, region table and types for the peripheral
//          access wait-state bridge.
// Assumes: core clock is the bridge clock; peripheral clocks are seen as
//          integer core/peripheral ratios.
// Notes:   region rows are searched in order, so the first match wins.
//
// Functional notes
// [RL1] CPU/DMA/interrupt/flash/debug region: 3 core cycles
// [RL2] system control: 3 cycles, listed sub-ranges 5
// [RL3] port/pin/event region: 3 B cycles, 2-3 faster
// [RL4] wide serial data access adds two cycles
// [RL5] rtc/watchdog/accuracy/module-stop: 3 B, 2-3 faster
// [RL6] pwm timers: read 6/5-6, write 4/3-4 B cycles
// [RL7] graphics/spi/crc/security: 3 peripheral-A cycles
// [RL8] correction/timers/divider/vref: 4 B, 3-4 faster
// [RL9] fractional range: min rounds down, max rounds nearest
// [RL10] counts are minimums; clock switching adds stalls
// [RL11] faster core clock adds one peripheral sync cycle
// [RL12] master must not touch unallocated addresses
// [RL13] counts hold only without another master's contention
// [RL14] decode region, insert its waits, then complete
package pacw_pkg;

  // ==========================================================
  // widths
  localparam int unsigned ADDR_W  = 32; // cpu address width
  localparam int unsigned DATA_W  = 32; // cpu data width
  localparam int unsigned CNT_W   = 4;  // wait counter width
  localparam int unsigned RATIO_W = 4;  // core/peripheral ratio width

  // ==========================================================
  // timing constants
  localparam logic [CNT_W-1:0]   SCI_WIDE_EXTRA = 4'h2; // wide data adder
  localparam logic [CNT_W-1:0]   UNMAPPED_CYC   = 4'h3; // unmapped answer
  localparam logic [CNT_W-1:0]   CNT_ONE        = 4'h1; // counter step
  localparam logic [RATIO_W-1:0] RATIO_ONE      = 4'h1; // equal clocks
  localparam logic [RATIO_W-1:0] PHASE_ZERO     = 4'h0; // divider restart

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    DOM_CORE = 2'h0,  // counted in core_clock
    DOM_PA   = 2'h1,  // counted in peripheral_clock_a
    DOM_PB   = 2'h2   // counted in peripheral_clock_b
  } pacw_dom_t;

  // sequence idle -> wait -> done -> idle, one bit per step except done -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b11
  } pacw_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] lo;   // first byte of region
    logic [ADDR_W-1:0] hi;   // last byte of region
    logic [CNT_W-1:0]  rd;   // read units
    logic [CNT_W-1:0]  wr;   // write units
    pacw_dom_t         dom;  // unit clock
    logic              wide; // wide serial data region
  } pacw_rgn_t;

  // ==========================================================
  // region table; the faster-core upper bound equals the equal-clock
  // figure everywhere, so one count per direction serves both.
  // ranges already rounded: lower bound down, upper to nearest [RL9]
  localparam int unsigned RGN_COUNT = 30;
  localparam pacw_rgn_t RGN_TABLE [RGN_COUNT] = '{
    '{32'h4000_0000, 32'h4000_6FFF, 4'h3, 4'h3, DOM_CORE, 1'b0}, // [RL1]
    '{32'h4001_9000, 32'h4001_9FFF, 4'h2, 4'h2, DOM_CORE, 1'b0},
    '{32'h4001_A000, 32'h4001_BFFF, 4'h3, 4'h3, DOM_CORE, 1'b0}, // [RL1]
    '{32'h4001_E400, 32'h4001_E412, 4'h5, 4'h5, DOM_CORE, 1'b0}, // [RL2]
    '{32'h4001_E414, 32'h4001_E420, 4'h5, 4'h5, DOM_CORE, 1'b0}, // [RL2]
    '{32'h4001_E422, 32'h4001_E4E0, 4'h5, 4'h5, DOM_CORE, 1'b0}, // [RL2]
    '{32'h4001_E4E2, 32'h4001_E4FF, 4'h5, 4'h5, DOM_CORE, 1'b0}, // [RL2]
    '{32'h4001_E000, 32'h4001_EFFF, 4'h3, 4'h3, DOM_CORE, 1'b0}, // [RL2]
    '{32'h4004_0000, 32'h4004_10FF, 4'h3, 4'h3, DOM_PB,   1'b0}, // [RL3]
    '{32'h4004_1240, 32'h4004_127F, 4'h3, 4'h3, DOM_PB,   1'b1}, // [RL4]
    '{32'h4004_2000, 32'h4004_21FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4004_4000, 32'h4004_70FF, 4'h3, 4'h3, DOM_PB,   1'b0}, // [RL5]
    '{32'h4005_2000, 32'h4005_207F, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4005_3100, 32'h4005_31FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4005_4100, 32'h4005_41FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4005_5000, 32'h4005_50FF, 4'h6, 4'h4, DOM_PB,   1'b0}, // [RL6]
    '{32'h4005_5300, 32'h4005_53FF, 4'h6, 4'h4, DOM_PB,   1'b0}, // [RL6]
    '{32'h4005_C000, 32'h4005_C1FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4005_D000, 32'h4005_D0FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4007_0800, 32'h4007_0DFF, 4'h3, 4'h3, DOM_PA,   1'b0}, // [RL7]
    '{32'h4007_2100, 32'h4007_21FF, 4'h3, 4'h3, DOM_PA,   1'b0}, // [RL7]
    '{32'h4007_4000, 32'h4007_40FF, 4'h3, 4'h3, DOM_PA,   1'b0}, // [RL7]
    '{32'h4008_0000, 32'h4008_00FF, 4'h3, 4'h3, DOM_PB,   1'b0},
    '{32'h4008_0400, 32'h4008_04FF, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h4008_4000, 32'h4008_41FF, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h4008_4400, 32'h4008_44FF, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h4008_4500, 32'h4008_457F, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h4008_4680, 32'h4008_46FF, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h4008_6A80, 32'h4008_6AFF, 4'h4, 4'h4, DOM_PB,   1'b0}, // [RL8]
    '{32'h400C_0000, 32'h400C_01FF, 4'h3, 4'h3, DOM_PA,   1'b0}  // [RL7]
  };

endpackage

/* rtl/pacw_region_dec.sv */
// Purpose: matches an address against the region table.
// Assumes: table rows earlier in the list take priority.
// Notes:   combinational; no state.
`timescale 1ns/1ns

module pacw_region_dec (
  pacw_dec_if.decoder dec
);

  // ==========================================================
  // range test, used once per table row
  function automatic logic inRange(
    input logic [pacw_pkg::ADDR_W-1:0] a,
    input logic [pacw_pkg::ADDR_W-1:0] lo,
    input logic [pacw_pkg::ADDR_W-1:0] hi
  );
    inRange = (a >= lo) && (a <= hi);
  endfunction

  logic [pacw_pkg::RGN_COUNT-1:0] hitVec; // one bit per row

  // per-row compare
  for (genvar i = 0; i < pacw_pkg::RGN_COUNT; i++) begin : g_row
    assign hitVec[i] = inRange(dec.addr, pacw_pkg::RGN_TABLE[i].lo,
                               pacw_pkg::RGN_TABLE[i].hi);
  end

  // lowest matching row wins, so narrow slow sub-ranges beat defaults
  always_comb begin
    dec.hit   = 1'b0;
    dec.rdCyc = '0;
    dec.wrCyc = '0;
    dec.dom   = pacw_pkg::DOM_CORE;
    dec.wide  = 1'b0;
    for (int i = pacw_pkg::RGN_COUNT - 1; i >= 0; i--) begin
      if (hitVec[i]) begin // [RL14]
        dec.hit   = 1'b1;
        dec.rdCyc = pacw_pkg::RGN_TABLE[i].rd;
        dec.wrCyc = pacw_pkg::RGN_TABLE[i].wr;
        dec.dom   = pacw_pkg::RGN_TABLE[i].dom;
        dec.wide  = pacw_pkg::RGN_TABLE[i].wide;
      end
    end
  end

endmodule // pacw_region_dec

/* tb/pacw_access_timer_monitor.sv */
// Purpose: port-level checks of the access timer.
// Assumes: single core clock domain.
// Notes:   wait count skipped after a clock switch stall.
`timescale 1ns/1ns

module pacw_access_timer_monitor (
  input wire logic                            clk,
  input wire logic                            rst_n,
  input wire logic                            cpuWrite,
  input wire logic                            cpuHalf,
  input wire logic [pacw_pkg::DATA_W-1:0]     cpuRdata,
  input wire logic                            cpuReady,
  input wire logic                            cpuBusy,
  input wire logic                            cpuUnmapped,
  input wire logic                            perSel,
  input wire logic                            perWrite,
  input wire logic [pacw_pkg::ADDR_W-1:0]     perAddr,
  input wire logic [pacw_pkg::DATA_W-1:0]     perWdata,
  input wire logic                            otherMasterBusy,
  input wire logic                            clkSwitchBusy,
  input wire logic [pacw_pkg::RATIO_W-1:0]    pclkaRatio,
  input wire logic [pacw_pkg::RATIO_W-1:0]    pclkbRatio
);
  // ==========================================================
  // helpers
  int   cnt_q;    // strobe cycles of the open access
  logic swSeen_q; // a switch stall hit this access
  int   latLo;    // shortest legal wait
  int   latHi;    // longest legal wait

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // count strobe cycles; reset between accesses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cnt_q <= 0;
    else if (perSel) cnt_q <= cnt_q + 1;
    else cnt_q <= 0;
  end

  // stall marker; stalled accesses are only minimums
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) swSeen_q <= 1'b0;
    else if (cpuReady) swSeen_q <= 1'b0;
    else if (clkSwitchBusy && cpuBusy) swSeen_q <= 1'b1;
  end

  // bounds from the held address
  always_comb begin
    latLo = pacw_tb_pkg::latMin(perAddr, perWrite, cpuHalf,
                                pclkaRatio, pclkbRatio);
    latHi = pacw_tb_pkg::latMax(perAddr, perWrite, cpuHalf,
                                pclkaRatio, pclkbRatio);
  end

  // ==========================================================
  // assertions
  a_ready_pulse: assert property (cpuReady |=> !cpuReady)
    else $error("ready held longer than one cycle");
  a_wait_count: assert property (cpuReady && !cpuUnmapped && !swSeen_q
    |-> cnt_q >= latLo && cnt_q <= latHi)
    else $error("wait count outside region figure");
  a_unmap_answer: assert property ($rose(cpuBusy) && !perSel
    |-> ##3 (cpuReady && cpuUnmapped))
    else $error("unmapped access not answered in time");
  a_unmap_zero: assert property (cpuUnmapped && !cpuWrite
    |-> cpuRdata == '0)
    else $error("unmapped read returned data");
  a_unmap_nosel: assert property (cpuUnmapped |-> !$past(perSel))
    else $error("strobe raised for unmapped access");
  a_held_steady: assert property (perSel && $past(perSel)
    |-> $stable(perAddr) && $stable(perWrite) && $stable(perWdata))
    else $error("peripheral request changed mid access");
  a_sel_ends: assert property ($fell(perSel) |-> cpuReady)
    else $error("strobe dropped without completion");
  a_other_blocks: assert property (otherMasterBusy && !cpuBusy
    && !cpuReady |=> !cpuBusy)
    else $error("access taken while another master busy");
  a_busy_span: assert property (cpuReady |-> cpuBusy)
    else $error("completion outside open access");

endmodule // pacw_access_timer_monitor

bind pacw_access_timer pacw_access_timer_monitor i_mon (.*);

/* tb/pacw_access_timer_test.sv */
// Purpose: self-checking bench for the access wait-state bridge.
// Assumes: 20 MHz core clock, inputs driven at falling edges.
// Notes:   latency counted in request-high edges since last answer.
`timescale 1ns/1ns

module pacw_access_timer_test;
  logic        clk = 1'b0;
  logic        rst_n, cpuReq, cpuWrite, cpuHalf;
  logic        otherMasterBusy, clkSwitchBusy;
  logic [31:0] cpuAddr, cpuWdata, cpuRdata, perAddr, perWdata, perRdata;
  logic        cpuReady, cpuBusy, cpuUnmapped, perSel, perWrite;
  logic [3:0]  pclkaRatio, pclkbRatio;
  int          err_total, total_checks, cnt;
  integer      seed = 32'he54c1fff;     // fixed seed
  logic [31:0] d;                       // random write data
  pacw_tb_pkg::pacw_exp_t expQ [$];     // pending answers
  pacw_tb_pkg::pacw_exp_t eHead;        // answer under check
  logic [31:0] tab [18] = '{32'h4000_5000, 32'h4001_A004,
    32'h4001_E400, 32'h4001_E413, 32'h4001_E421, 32'h4001_E4E1,
    32'h4001_E4FF, 32'h4001_E500, 32'h4004_0800, 32'h4004_1240,
    32'h4004_1260, 32'h4004_4200, 32'h4005_5000, 32'h4005_5300,
    32'h4007_2100, 32'h400C_0010, 32'h4008_0400, 32'h4008_6A80};

  always #25 clk = ~clk;

  pacw_access_timer i_pacw_access_timer (.*);
  pacw_per_model i_pacw_per_model (.*);

  // ==========================================================
  // compare tasks and the end of run
  task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got %0h want %0h", $time, got, exp);
    end
  endtask

  task automatic chkLat(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("ERROR t=%0t wait %0h want %0h..%0h", $time, got, lo, hi);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // one access; request held until answered, left high afterwards
  task automatic go(input logic [31:0] a, input logic w, input logic h,
                    input logic [31:0] dv, input int extra,
                    input bit unm, input bit chkD);
    pacw_tb_pkg::pacw_exp_t e;
    int n;
    e.lo = extra + pacw_tb_pkg::latMin(a, w, h, pclkaRatio, pclkbRatio);
    e.hi = extra + pacw_tb_pkg::latMax(a, w, h, pclkaRatio, pclkbRatio);
    if (unm) e.lo = int'(pacw_pkg::UNMAPPED_CYC);
    if (unm) e.hi = e.lo;
    e.d = unm ? 32'h0 : dv;
    e.chkD = chkD && !w;
    e.unm = unm;
    expQ.push_back(e);
    {cpuAddr, cpuWrite, cpuHalf, cpuWdata, cpuReq} = {a, w, h, dv, 1'b1};
    n = 0;
    do begin @(posedge clk); n++; end while (cpuReady !== 1'b1 && n < 300);
    chkVal({31'h0, cpuReady}, 32'h1);
    @(negedge clk);
  endtask

  task automatic idle(input int k);
    cpuReq = 1'b0;
    repeat (k) @(negedge clk);
  endtask

  // write then read back each address in tab, the two back to back
  task automatic runTable;
    logic h;
    foreach (tab[i]) begin
      d = $random(seed);
      h = ($random(seed) & 1) | (i == 9);
      go(tab[i], 1'b1, h, d, 0, 1'b0, 1'b0);
      go(tab[i], 1'b0, h, d, 0, 1'b0, 1'b1);
      idle(1);
    end
  endtask

  // ==========================================================
  // answer watcher: oldest note against each completion
  always @(posedge clk) begin
    if (rst_n === 1'b1 && cpuReady === 1'b1) begin
      if (expQ.size() == 0) chkVal(32'h1, 32'h0);
      else begin
        eHead = expQ.pop_front();
        // the accept edge itself is counted, so drop it here
        chkLat(cnt - 1, eHead.lo, eHead.hi);
        chkVal({31'h0, cpuUnmapped}, {31'h0, eHead.unm});
        if (eHead.chkD) chkVal(cpuRdata, eHead.d);
      end
      cnt = 0;
    end else if (cpuReq === 1'b1) cnt++;
  end

  // hang guard, well past the expected run length
  initial begin
    #(50 * 6000);
    err_total++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    {rst_n, cpuReq, cpuWrite, cpuHalf, otherMasterBusy} = 5'h0;
    {clkSwitchBusy, cpuAddr, cpuWdata, cnt} = '0;
    {pclkaRatio, pclkbRatio} = 8'h11;
    repeat (2) @(negedge clk);
    chkVal({28'h0, cpuReady, cpuBusy, cpuUnmapped, perSel}, 32'h0);
    chkVal(cpuRdata, 32'h0);
    rst_n = 1'b1;
    runTable();
    $display("equal clock table done");
    {pclkaRatio, pclkbRatio} = 8'h32;
    idle(8);
    runTable();
    {pclkaRatio, pclkbRatio} = 8'h11;
    idle(8);
    $display("faster core table done");
    go(32'h4001_0000, 1'b0, 1'b0, 32'h0, 0, 1'b1, 1'b1);
    go(32'h4003_0000, 1'b1, 1'b0, 32'h1, 0, 1'b1, 1'b0);
    idle(1);
    $display("unmapped test done");
    otherMasterBusy = 1'b1;
    fork
      go(32'h4000_5000, 1'b0, 1'b0, 32'h0, 4, 1'b0, 1'b0);
      begin repeat (4) @(negedge clk); otherMasterBusy = 1'b0; end
    join
    idle(1);
    fork
      go(32'h4001_E400, 1'b0, 1'b0, 32'h0, 2, 1'b0, 1'b0);
      begin
        @(negedge clk);
        clkSwitchBusy = 1'b1;
        repeat (2) @(negedge clk);
        clkSwitchBusy = 1'b0;
      end
    join
    idle(2);
    $display("stall tests done");
    wrap_up();
  end
endmodule // pacw_access_timer_test

/* tb/pacw_per_model.sv */
// Purpose: peripheral register space behind the bridge.
// Assumes: answers combinationally while strobed.
// Notes:   undriven read bus toggles so stale data never matches.
`timescale 1ns/1ns

module pacw_per_model (
  input  wire logic        clk,
  input  wire logic        perSel,
  input  wire logic        perWrite,
  input  wire logic [31:0] perAddr,
  input  wire logic [31:0] perWdata,
  output logic      [31:0] perRdata
);
  logic [31:0] mem [64];                   // word store
  logic [31:0] noise_q = 32'hA5A5_5A5A;    // idle bus pattern

  // ==========================================================
  // store writes; never contends with the bridge
  always @(posedge clk) begin
    if (perSel && perWrite) mem[perAddr[7:2]] <= perWdata;
    noise_q <= ~noise_q;
  end

  initial foreach (mem[i]) mem[i] = 32'h5A00_0000 + i;

  // data only while selected
  assign perRdata = perSel ? mem[perAddr[7:2]] : noise_q;
endmodule // pacw_per_model

/* tb/pacw_tb_pkg.sv */
// Purpose: expected wait counts for the access timer bench.
// Assumes: ratio 0 or 1 means equal clocks.
// Notes:   shared by the monitor and the test, kept apart from rtl.
package pacw_tb_pkg;

  // ==========================================================
  // expectation record
  typedef struct {
    int          lo;   // fewest cycles allowed
    int          hi;   // most cycles allowed
    logic [31:0] d;    // read data expected
    bit          chkD; // compare read data
    logic        unm;  // unmapped flag expected
  } pacw_exp_t;

  // ==========================================================
  // units per region, direction and width
  function automatic int unitCount(logic [31:0] a, logic w, logic h);
    if (a inside {32'h4001_E413, 32'h4001_E421, 32'h4001_E4E1})
      return 3;
    if (a inside {[32'h4001_E400:32'h4001_E4FF]})
      return 5;
    if (a inside {[32'h4005_5000:32'h4005_53FF]})
      return w ? 4 : 6;
    if (a inside {[32'h4008_0400:32'h4008_04FF],
                  [32'h4008_4000:32'h4008_6AFF]})
      return 4;
    if (a inside {[32'h4004_1240:32'h4004_127F]})
      return h ? 5 : 3;
    return 3;
  endfunction

  // ratio that paces a region; core regions count in core cycles
  function automatic int ratioOf(logic [31:0] a, logic [3:0] ra,
                                 logic [3:0] rb);
    int r;
    r = (a[31:16] inside {16'h4007, 16'h400C}) ? int'(ra) : int'(rb);
    if (a < 32'h4004_0000 || r < 2)
      r = 1;
    return r;
  endfunction

  // first tick may land anywhere in a period, last one ends it
  function automatic int latMin(logic [31:0] a, logic w, logic h,
                                logic [3:0] ra, logic [3:0] rb);
    return (unitCount(a, w, h) - 1) * ratioOf(a, ra, rb) + 1;
  endfunction

  function automatic int latMax(logic [31:0] a, logic w, logic h,
                                logic [3:0] ra, logic [3:0] rb);
    return unitCount(a, w, h) * ratioOf(a, ra, rb);
  endfunction

endpackage
